/* fesp_regs.vh */
// Constants of the flash erase, pause and power-down sequencer.
// Assumes a 25 MHz sequencer clock and a mode 0 serial link.
`ifndef FESP_REGS_VH
`define FESP_REGS_VH

// Opcodes handled by the sequencer.
`define FESP_OPC_LATCH_SET 8'h06
`define FESP_OPC_LATCH_CLR 8'h04
`define FESP_OPC_STATUS_READ 8'h05
`define FESP_OPC_ERASE_32K 8'h52
`define FESP_OPC_ERASE_64K 8'hD8
`define FESP_OPC_ERASE_ALL_A 8'hC7
`define FESP_OPC_ERASE_ALL_B 8'h60
`define FESP_OPC_PAUSE 8'h75
`define FESP_OPC_RESUME 8'h7A
`define FESP_OPC_POWER_DOWN 8'hB9
`define FESP_OPC_RELEASE 8'hAB

// Frame bit counts.
`define FESP_BITCNT_ZERO 6'h00
`define FESP_BITCNT_ONE 6'h01
`define FESP_BITCNT_MAX 6'h3F
`define FESP_OPC_LAST 6'h07
`define FESP_OPC_BITS 6'h08
`define FESP_ADDR_LAST 6'h1F
`define FESP_ADDR_BITS 6'h20

// Block address masks and erase kinds.
`define FESP_MASK_32K 24'hFF8000
`define FESP_MASK_64K 24'hFF0000
`define FESP_ADDR_ZERO 24'h000000
`define FESP_KIND_NONE 2'h0
`define FESP_KIND_32K 2'h1
`define FESP_KIND_64K 2'h2
`define FESP_KIND_ALL 2'h3

// Status byte field positions and read bit index.
`define FESP_SR_BUSY 0
`define FESP_SR_LATCH 1
`define FESP_SR_PAUSED 7
`define FESP_SR_FIRST 3'h7
`define FESP_SR_SECOND 3'h6
`define FESP_SR_IDX_ONE 3'h1
`define FESP_SR_EMPTY 8'h00

// Timing, in ns, and the derived cycle counts (longest times round down).
`define FESP_CLK_NS 40
`define FESP_CYC_PER_US (1000 / `FESP_CLK_NS)
`define FESP_PAUSE_LAT_NS 20000
`define FESP_PD_ENTRY_NS 3000
`define FESP_WAKE_NS 3000
`define FESP_PAUSE_LAT_CYC ((`FESP_PAUSE_LAT_NS / `FESP_CLK_NS) < 1 ? 1 : (`FESP_PAUSE_LAT_NS / `FESP_CLK_NS))
`define FESP_PD_ENTRY_CYC ((`FESP_PD_ENTRY_NS / `FESP_CLK_NS) < 1 ? 1 : (`FESP_PD_ENTRY_NS / `FESP_CLK_NS))
`define FESP_WAKE_CYC ((`FESP_WAKE_NS / `FESP_CLK_NS) < 1 ? 1 : (`FESP_WAKE_NS / `FESP_CLK_NS))
`define FESP_CNT_ZERO 32'h00000000
`define FESP_CNT_ONE 32'h00000001

`endif

/* fesp_sync.v */
// Three-stage input synchroniser with agreement filter.
// Assumes rst_n is already synchronous to sys_clk.
`timescale 1ns/100ps
module fesp_sync #(
  parameter [0:0] INIT = 1'b0
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Pin and clean copy
  input wire din,
  output reg dout
);
  reg ff1;
  reg ff2;
  reg ff3;

  // A change is taken only when the second and third stages agree.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1 <= INIT;
      ff2 <= INIT;
      ff3 <= INIT;
      dout <= INIT;
    end else begin
      ff1 <= din;
      ff2 <= ff1;
      ff3 <= ff2;
      if (ff2 == ff3) begin
        dout <= ff3;
      end
    end
  end
endmodule // fesp_sync

/* fesp_timer.v */
// Loadable down counter that pulses once when it runs out.
// Assumes load values of at least one cycle.
`timescale 1ns/100ps
`include "fesp_regs.vh"
module fesp_timer (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Control
  input wire load,
  input wire [31:0] load_val,
  input wire hold,
  // Result
  output reg expire
);
  reg [31:0] count;

  // Holding freezes the remainder, so a paused erase resumes where it stopped.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `FESP_CNT_ZERO;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        count <= load_val;
      end else if (!hold && count != `FESP_CNT_ZERO) begin
        count <= count - `FESP_CNT_ONE;
        if (count == `FESP_CNT_ONE) begin
          expire <= 1'b1;
        end
      end
    end
  end
endmodule // fesp_timer

/* fesp_top.v */
// Erase, pause and power-down sequencer of a serial NOR flash.
// Assumes a mode 0 link much slower than sys_clk and an external array.
// Behaviour
// - Opcode 52h with 24-bit address erases the containing 32 KB block.
// - Opcode D8h with 24-bit address erases the containing 64 KB block.
// - Opcode C7h or 60h without address erases the whole array.
// - Erase commands are taken only while the write latch flag is set.
// - Busy reads 1 during a self-timed erase; status reads keep working.
// - Finishing an erase clears the write latch flag.
// - Protected block targets skip block erase; any protection skips chip erase.
// - Opcode 75h pauses a running block erase.
// - While erase is paused, status write and all erases are refused.
// - While program is paused, status write and programs are refused.
// - Pause during chip erase is ignored; chip erase goes on.
// - Pause is taken only with paused flag 0 and busy 1.
// - Pause sets paused flag at once, drops busy within pause latency.
// - Power loss ends the paused state and clears the paused flag.
// - Opcode 7Ah is taken only with paused flag 1 and busy 0.
// - Resume clears paused flag at once and sets busy within 200 ns.
// - Resume is ignored when the pause was ended by power loss.
// - Aligned B9h enters low-power standby after the entry time.
// - In standby only ABh is recognised, status reads included.
`timescale 1ns/100ps
`include "fesp_regs.vh"
module fesp_top #(
  parameter HALF_BLOCK_ERASE_US = 1000,
  parameter LARGE_BLOCK_ERASE_US = 2000,
  parameter FULL_ARRAY_ERASE_US = 10000
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Serial link
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  // Protection answers
  input wire target_protected,
  input wire any_protected,
  // Protection query
  output reg [23:0] query_base,
  output reg [1:0] query_kind,
  // Array erase control
  output reg [23:0] erase_base,
  output reg [1:0] erase_kind,
  output reg erase_run,
  output reg erase_done,
  // Status
  output reg busy_flag,
  output reg write_latch_flag,
  output reg paused_op_flag,
  output reg low_power
);
  localparam [31:0] HALF_BLOCK_ERASE_CYC = HALF_BLOCK_ERASE_US * `FESP_CYC_PER_US;
  localparam [31:0] LARGE_BLOCK_ERASE_CYC = LARGE_BLOCK_ERASE_US * `FESP_CYC_PER_US;
  localparam [31:0] FULL_ARRAY_ERASE_CYC = FULL_ARRAY_ERASE_US * `FESP_CYC_PER_US;
  localparam [31:0] PAUSE_LATENCY_CYC = `FESP_PAUSE_LAT_CYC;
  localparam [31:0] POWER_DOWN_ENTRY_CYC = `FESP_PD_ENTRY_CYC;
  localparam [31:0] WAKE_UP_CYC = `FESP_WAKE_CYC;

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ERASE = 7'h02;
  localparam [6:0] ST_PAUSING = 7'h04;
  localparam [6:0] ST_PAUSED = 7'h08;
  localparam [6:0] ST_PD_ENTRY = 7'h10;
  localparam [6:0] ST_PD = 7'h20;
  localparam [6:0] ST_WAKE = 7'h40;
  reg rst_ff1, rst_ff2;
  wire rst_n, sclk_q, cs_n_q, mosi_q;
  reg sclk_prev, cs_prev;
  reg [5:0] bit_cnt;
  reg [31:0] shift_in;
  reg [7:0] opcode, status_byte;
  reg read_active;
  reg [2:0] tx_idx;
  reg [6:0] state, next_state;
  reg next_busy, next_paused, next_latch, next_erase_done;
  reg [23:0] next_erase_base;
  reg [1:0] next_erase_kind;
  reg op_load, aux_load;
  reg [31:0] op_load_val, aux_load_val;
  wire op_expire, aux_expire;
  wire [7:0] opc_now;
  wire [23:0] addr_now;
  wire sclk_rise, cs_fall, cs_rise, one_byte, addr_cmd, read_allowed;
  // Reset is released through two flops so every block leaves reset together.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_ff1 <= 1'b0;
      rst_ff2 <= 1'b0;
    end else begin
      rst_ff1 <= 1'b1;
      rst_ff2 <= rst_ff1;
    end
  end
  assign rst_n = rst_ff2;
  // Link pins.
  fesp_sync #(.INIT(1'b0)) u_sync_sclk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(spi_sclk),
    .dout(sclk_q)
  );
  fesp_sync #(.INIT(1'b1)) u_sync_cs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(spi_cs_n),
    .dout(cs_n_q)
  );
  fesp_sync #(.INIT(1'b0)) u_sync_mosi (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(spi_mosi),
    .dout(mosi_q)
  );
  // All three pins see the same delay, so data stays aligned with its edge.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      sclk_prev <= sclk_q;
      cs_prev <= cs_n_q;
    end
  end
  assign sclk_rise = sclk_q & ~sclk_prev & ~cs_n_q;
  assign cs_fall = ~cs_n_q & cs_prev;
  assign cs_rise = cs_n_q & ~cs_prev;
  assign opc_now = {shift_in[6:0], mosi_q};
  assign addr_now = {shift_in[22:0], mosi_q};
  // Only exact frame lengths count; other deselects drop the command.
  assign one_byte = (bit_cnt == `FESP_OPC_BITS);
  assign addr_cmd = (bit_cnt == `FESP_ADDR_BITS);
  assign read_allowed = (state != ST_PD) && (state != ST_WAKE);
  // Frame receiver and protection query.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= `FESP_BITCNT_ZERO;
      shift_in <= `FESP_CNT_ZERO;
      opcode <= `FESP_SR_EMPTY;
      query_base <= `FESP_ADDR_ZERO;
      query_kind <= `FESP_KIND_NONE;
    end else if (cs_fall) begin
      bit_cnt <= `FESP_BITCNT_ZERO;
      opcode <= `FESP_SR_EMPTY;
      query_kind <= `FESP_KIND_NONE;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[30:0], mosi_q};
      if (bit_cnt != `FESP_BITCNT_MAX) begin
        bit_cnt <= bit_cnt + `FESP_BITCNT_ONE;
      end
      if (bit_cnt == `FESP_OPC_LAST) begin
        opcode <= opc_now;
      end
      if (bit_cnt == `FESP_ADDR_LAST && state == ST_IDLE) begin
        if (opcode == `FESP_OPC_ERASE_32K) begin
          query_base <= addr_now & `FESP_MASK_32K;
          query_kind <= `FESP_KIND_32K;
        end else if (opcode == `FESP_OPC_ERASE_64K) begin
          query_base <= addr_now & `FESP_MASK_64K;
          query_kind <= `FESP_KIND_64K;
        end
      end
    end
  end
  // The status byte is sampled bit by bit, so repeated bytes show live busy.
  always @* begin
    status_byte = `FESP_SR_EMPTY;
    status_byte[`FESP_SR_BUSY] = busy_flag;
    status_byte[`FESP_SR_LATCH] = write_latch_flag;
    status_byte[`FESP_SR_PAUSED] = paused_op_flag;
  end

  // Data leaves just after each rising edge; the sync delay is too long to
  // meet a falling-edge launch, and the host samples on the next rise.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_active <= 1'b0;
      tx_idx <= `FESP_SR_FIRST;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (cs_n_q) begin
      read_active <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (sclk_rise) begin
      if (bit_cnt == `FESP_OPC_LAST && opc_now == `FESP_OPC_STATUS_READ && read_allowed) begin
        read_active <= 1'b1;
        spi_miso_oe <= 1'b1;
        spi_miso <= status_byte[`FESP_SR_FIRST];
        tx_idx <= `FESP_SR_SECOND;
      end else if (read_active) begin
        spi_miso <= status_byte[tx_idx];
        tx_idx <= tx_idx - `FESP_SR_IDX_ONE;
      end
    end
  end

  // Sequencer decisions.
  always @* begin
    next_state = state;
    next_busy = busy_flag;
    next_paused = paused_op_flag;
    next_latch = write_latch_flag;
    next_erase_done = 1'b0;
    next_erase_base = erase_base;
    next_erase_kind = erase_kind;
    op_load = 1'b0;
    op_load_val = FULL_ARRAY_ERASE_CYC;
    aux_load = 1'b0;
    aux_load_val = PAUSE_LATENCY_CYC;
    case (state)
      ST_IDLE: begin
        if (cs_rise && one_byte) begin
          case (opcode)
            `FESP_OPC_LATCH_SET: next_latch = 1'b1;
            `FESP_OPC_LATCH_CLR: next_latch = 1'b0;
            `FESP_OPC_ERASE_ALL_A, `FESP_OPC_ERASE_ALL_B: begin
              if (write_latch_flag && !any_protected) begin
                next_state = ST_ERASE;
                next_busy = 1'b1;
                next_erase_base = `FESP_ADDR_ZERO;
                next_erase_kind = `FESP_KIND_ALL;
                op_load = 1'b1;
                op_load_val = FULL_ARRAY_ERASE_CYC;
              end
            end
            `FESP_OPC_POWER_DOWN: begin
              next_state = ST_PD_ENTRY;
              aux_load = 1'b1;
              aux_load_val = POWER_DOWN_ENTRY_CYC;
            end
            default: begin
            end
          endcase
        end else if (cs_rise && addr_cmd && query_kind != `FESP_KIND_NONE) begin
          if (write_latch_flag && !target_protected) begin
            next_state = ST_ERASE;
            next_busy = 1'b1;
            next_erase_base = query_base;
            next_erase_kind = query_kind;
            op_load = 1'b1;
            if (query_kind == `FESP_KIND_32K) begin
              op_load_val = HALF_BLOCK_ERASE_CYC;
            end else begin
              op_load_val = LARGE_BLOCK_ERASE_CYC;
            end
          end
        end
      end
      ST_ERASE: begin
        // Completion wins over a pause that lands in the same cycle.
        if (op_expire) begin
          next_state = ST_IDLE;
          next_busy = 1'b0;
          next_latch = 1'b0;
          next_erase_done = 1'b1;
        end else if (cs_rise && one_byte && opcode == `FESP_OPC_PAUSE) begin
          if (!paused_op_flag && busy_flag && erase_kind != `FESP_KIND_ALL) begin
            next_state = ST_PAUSING;
            next_paused = 1'b1;
            aux_load = 1'b1;
            aux_load_val = PAUSE_LATENCY_CYC;
          end
        end
      end
      ST_PAUSING: begin
        if (aux_expire) begin
          next_state = ST_PAUSED;
          next_busy = 1'b0;
        end
      end
      ST_PAUSED: begin
        // Status write and every erase opcode fall through unrecognised here;
        // no program path exists, so a paused program can never arise.
        if (cs_rise && one_byte) begin
          case (opcode)
            `FESP_OPC_LATCH_SET: next_latch = 1'b1;
            `FESP_OPC_LATCH_CLR: next_latch = 1'b0;
            `FESP_OPC_RESUME: begin
              if (paused_op_flag && !busy_flag) begin
                next_state = ST_ERASE;
                next_paused = 1'b0;
                next_busy = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_PD_ENTRY: begin
        if (aux_expire) begin
          next_state = ST_PD;
        end
      end
      ST_PD: begin
        if (cs_rise && one_byte && opcode == `FESP_OPC_RELEASE) begin
          next_state = ST_WAKE;
          aux_load = 1'b1;
          aux_load_val = WAKE_UP_CYC;
        end
      end
      ST_WAKE: begin
        if (aux_expire) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Erase time runs only in the erase state and freezes while paused.
  fesp_timer u_op_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(op_load),
    .load_val(op_load_val),
    .hold(state != ST_ERASE),
    .expire(op_expire)
  );

  // Pause latency, standby entry and wake-up share one counter.
  fesp_timer u_aux_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(aux_load),
    .load_val(aux_load_val),
    .hold(1'b0),
    .expire(aux_expire)
  );

  // A power loss is a reset: nothing paused survives, so resume finds nothing.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      busy_flag <= 1'b0;
      paused_op_flag <= 1'b0;
      write_latch_flag <= 1'b0;
      erase_base <= `FESP_ADDR_ZERO;
      erase_kind <= `FESP_KIND_NONE;
      erase_run <= 1'b0;
      erase_done <= 1'b0;
      low_power <= 1'b0;
    end else begin
      state <= next_state;
      busy_flag <= next_busy;
      paused_op_flag <= next_paused;
      write_latch_flag <= next_latch;
      erase_base <= next_erase_base;
      erase_kind <= next_erase_kind;
      erase_run <= (next_state == ST_ERASE);
      erase_done <= next_erase_done;
      low_power <= (next_state == ST_PD);
    end
  end
endmodule // fesp_top

/* fesp_props.sv */
// Checker of the sequencer's flag, erase and power-down outputs.
// Assumes it is bound into fesp_top and sees only that module's ports.
`timescale 1ns/100ps
module fesp_props (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Observed outputs
  input wire spi_miso_oe,
  input wire [23:0] query_base,
  input wire [1:0] query_kind,
  input wire [23:0] erase_base,
  input wire [1:0] erase_kind,
  input wire erase_run,
  input wire erase_done,
  input wire busy_flag,
  input wire write_latch_flag,
  input wire paused_op_flag,
  input wire low_power
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  run_busy_a:
    assert property (erase_run |-> busy_flag && write_latch_flag && !paused_op_flag)
    else $error("erase runs without busy or latch");
  done_clear_a:
    assert property (erase_done |-> $past(erase_run) && !busy_flag && !write_latch_flag && !erase_run)
    else $error("erase end left flags set");
  pause_take_a:
    assert property ($rose(paused_op_flag) |-> $past(busy_flag) && erase_kind != 2'h3 && !erase_run)
    else $error("pause taken in a wrong state");
  busy_drop_a:
    assert property ($rose(paused_op_flag) |-> busy_flag ##[1:505] !busy_flag)
    else $error("busy not dropped within pause latency");
  resume_busy_a:
    assert property ($fell(paused_op_flag) && $past(reset_n) |-> busy_flag && erase_run)
    else $error("resume did not restart the erase");
  erase_hold_a:
    assert property (erase_run && $past(erase_run) |-> $stable(erase_base) && $stable(erase_kind))
    else $error("erase target moved while running");
  query_mask_a:
    assert property (query_kind != 2'h0 |-> (query_base & (query_kind[1] ? 24'h00FFFF : 24'h007FFF)) == 24'h000000)
    else $error("block base keeps low address bits");
  chip_base_a:
    assert property (erase_run && erase_kind == 2'h3 |-> erase_base == 24'h000000)
    else $error("chip erase with nonzero base");
  lp_quiet_a:
    assert property (low_power |-> !spi_miso_oe && !busy_flag && !paused_op_flag)
    else $error("activity in low power");
  wake_idle_a:
    assert property ($fell(low_power) && $past(reset_n) |-> (!busy_flag && !erase_run && !paused_op_flag)[*8])
    else $error("command taken during wake");
  cover property (erase_done);
  cover property ($rose(paused_op_flag));
  cover property ($rose(low_power));
  cover property (erase_run && erase_kind == 2'h3);
endmodule // fesp_props

bind fesp_top fesp_props i_fesp_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .spi_miso_oe(spi_miso_oe), .query_base(query_base),
  .query_kind(query_kind), .erase_base(erase_base), .erase_kind(erase_kind), .erase_run(erase_run),
  .erase_done(erase_done), .busy_flag(busy_flag), .write_latch_flag(write_latch_flag),
  .paused_op_flag(paused_op_flag), .low_power(low_power)
);

/* fesp_host.sv */
// Host side of the serial link: mode 0 frames with a 320 ns link clock.
// Assumes the bench calls frame from one process at a time.
`timescale 1ns/100ps
module fesp_host (
  // Link pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  logic oe_seen;
  initial begin
    spi_sclk = 1'h0;
    spi_cs_n = 1'h1;
    spi_mosi = 1'h0;
    oe_seen = 1'h0;
  end
  // Sends the low n bits of w MSB first and collects the byte after the opcode.
  task automatic frame(input logic [31:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    oe_seen = 1'h0;
    #13 spi_cs_n = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_mosi = w[i];
      #160 spi_sclk = 1'h1;
      // An undriven line has no pull, so it shows the inverse and stale data cannot pass.
      if (i < n - 8 && i >= n - 16) rd = {rd[6:0], spi_miso_oe === 1'h1 ? spi_miso : ~spi_miso};
      if (spi_miso_oe === 1'h1) oe_seen = 1'h1;
      #160 spi_sclk = 1'h0;
    end
    // The clock stands still between frames; deselect comes after whole bits only.
    #160 spi_cs_n = 1'h1;
    // The data line has no pull, so a stale bit must not look valid.
    spi_mosi = ~spi_mosi;
    #400;
  endtask
endmodule // fesp_host

/* tb.sv */
// Self-checking bench of the erase, pause and power-down sequencer.
// Assumes fesp_host on the link and fesp_props bound into the top.
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic target_protected = 1'h0;
  logic any_protected = 1'h0;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  wire [23:0] query_base, erase_base;
  wire [1:0] query_kind, erase_kind;
  wire erase_run, erase_done, busy_flag, write_latch_flag, paused_op_flag, low_power;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h00003C9F;
  logic [7:0] rd;
  logic [23:0] addr;
  always #20 sys_clk = ~sys_clk;
  // Erase times cut to 20, 30 and 40 us so pauses still land inside an erase.
  fesp_top #(.HALF_BLOCK_ERASE_US(20), .LARGE_BLOCK_ERASE_US(30), .FULL_ARRAY_ERASE_US(40)) i_fesp_top (
    .sys_clk(sys_clk), .reset_n(reset_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .target_protected(target_protected),
    .any_protected(any_protected), .query_base(query_base), .query_kind(query_kind),
    .erase_base(erase_base), .erase_kind(erase_kind), .erase_run(erase_run), .erase_done(erase_done),
    .busy_flag(busy_flag), .write_latch_flag(write_latch_flag), .paused_op_flag(paused_op_flag),
    .low_power(low_power));
  fesp_host i_fesp_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [23:0] block_of(input logic [23:0] a, input logic wide);
    return wide ? {a[23:16], 16'h0000} : {a[23:15], 15'h0000};
  endfunction
  // Flags f are busy, latch, paused, low power; the status byte puts them at 0, 1, 7.
  function automatic logic [7:0] st(input logic [3:0] f);
    return {f[1], 5'h00, f[2], f[3]};
  endfunction
  task automatic chk_flag(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_val(input string nm, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic send(input logic [31:0] w, input int n);
    i_fesp_host.frame(w, n, rd);
    cyc(12);
  endtask
  task automatic flags(input logic [3:0] f);
    chk_val("flags", {20'h00000, f}, {20'h00000, busy_flag, write_latch_flag, paused_op_flag, low_power});
  endtask
  task automatic status_is(input logic [3:0] f, input logic oe);
    send(32'h00000500, 16);
    // Undriven, the line reads as the inverse of the level reset left in the output flop.
    chk_val("status", {16'h0000, oe ? st(f) : 8'hFF}, {16'h0000, rd});
    chk_flag("miso_oe", oe, i_fesp_host.oe_seen);
  endtask
  task automatic wait_done(input int lim);
    for (int k = 0; k < lim && erase_done !== 1'h1; k++) cyc(1);
    chk_flag("erase_done", 1'h1, erase_done);
    flags(4'h0);
  endtask
  task automatic new_addr();
    repeat (8) seed = next_rand(seed);
    addr = seed[23:0];
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    reset_n = 1'h1;
    cyc(8);
    flags(4'h0);
    status_is(4'h0, 1'h1);
    send(32'h52000000, 32);
    flags(4'h0);
    send(32'h75, 8);
    send(32'h7A, 8);
    flags(4'h0);
    send(32'h06, 8);
    send(32'h04, 8);
    flags(4'h0);
    send(32'h60, 8);
    chk_flag("erase_run", 1'h0, erase_run);
    $display("test idle commands done");
    new_addr();
    send(32'h06, 8);
    status_is(4'h4, 1'h1);
    target_protected = 1'h1;
    send({8'h52, addr}, 32);
    target_protected = 1'h0;
    flags(4'h4);
    send({8'h52, addr} >> 1, 31);
    flags(4'h4);
    send({8'h52, addr}, 32);
    flags(4'hC);
    chk_flag("erase_run", 1'h1, erase_run);
    chk_val("query_base", block_of(addr, 1'h0), query_base);
    chk_val("erase_base", block_of(addr, 1'h0), erase_base);
    chk_val("erase_kind", 24'h000001, {22'h000000, erase_kind});
    status_is(4'hC, 1'h1);
    cyc(250);
    flags(4'hC);
    wait_done(600);
    $display("test half block erase done");
    new_addr();
    send(32'h06, 8);
    send({8'hD8, addr}, 32);
    chk_val("query_base", block_of(addr, 1'h1), query_base);
    chk_val("erase_kind", 24'h000002, {22'h000000, erase_kind});
    chk_val("query_kind", 24'h000002, {22'h000000, query_kind});
    send(32'h75, 8);
    flags(4'hE);
    chk_flag("erase_run", 1'h0, erase_run);
    for (int k = 0; k < 520 && busy_flag !== 1'h0; k++) cyc(1);
    flags(4'h6);
    status_is(4'h6, 1'h1);
    send({8'h52, addr}, 32);
    send(32'hC7, 8);
    flags(4'h6);
    send(32'h75, 8);
    flags(4'h6);
    send(32'h7A, 8);
    flags(4'hC);
    chk_flag("erase_run", 1'h1, erase_run);
    wait_done(800);
    $display("test pause and resume done");
    for (int j = 0; j < 2; j++) begin
      send(32'h06, 8);
      any_protected = 1'h1;
      send(j ? 32'h60 : 32'hC7, 8);
      any_protected = 1'h0;
      flags(4'h4);
      send(j ? 32'h60 : 32'hC7, 8);
      chk_val("erase_kind", 24'h000003, {22'h000000, erase_kind});
      send(32'h75, 8);
      flags(4'hC);
      wait_done(1100);
    end
    $display("test chip erase done");
    new_addr();
    send(32'h06, 8);
    send({8'hD8, addr}, 32);
    send(32'h75, 8);
    flags(4'hE);
    reset_n = 1'h0;
    cyc(3);
    reset_n = 1'h1;
    cyc(8);
    flags(4'h0);
    send(32'h7A, 8);
    flags(4'h0);
    $display("test power loss done");
    send(32'h172, 9);
    cyc(80);
    flags(4'h0);
    send(32'hB9, 8);
    cyc(80);
    flags(4'h1);
    status_is(4'h0, 1'h0);
    send(32'h06, 8);
    flags(4'h1);
    send(32'hAB, 8);
    flags(4'h0);
    cyc(80);
    send(32'h06, 8);
    flags(4'h4);
    $display("test power down done");
    tally_and_finish();
  end
  // The tests need about 10000 cycles; this allows five times that.
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end
endmodule // tb
